/* File: rtl/sbal_pkg.sv */
// constants for the sixteen bit absolute load and store sequencer
// Operation
// - ED, 01 pair 1011, two address bytes: load
// - first byte to low half, next to high
// - pair code 00..11 picks the four pairs
// - DD 2A loads index_x from memory
// - FD 2A loads index_y from memory
// - prefixed loads and stores take 20 states, six cycles
// - plain 22 stores third_pair in 16 states
// - ED, 01 pair 0011: store selected pair
// - DD 22 stores index_x low then high
// - FD 22 stores index_y low then high
// - earlier operand byte is the low address half
// - plain F9 copies third_pair, six states
// - DD F9 copies index_x, ten states
// - FD F9 copies index_y, same timing
// - condition flags never change
package sbal_pkg;
    // ****************************************
    // widths and opcodes
    // ****************************************
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [7:0] NO_PRE = 8'h00;
    localparam logic [7:0] PRE_ED = 8'hED;
    localparam logic [7:0] PRE_IX = 8'hDD;
    localparam logic [7:0] PRE_IY = 8'hFD;
    localparam logic [7:0] OP_LD_IDX = 8'h2A;
    localparam logic [7:0] OP_STORE = 8'h22;
    localparam logic [7:0] OP_SP_COPY = 8'hF9;
    localparam logic [1:0] ED_GROUP = 2'h1;
    localparam logic [3:0] ED_LD_LOW = 4'hB;
    localparam logic [3:0] ED_ST_LOW = 4'h3;
    // ****************************************
    // state lengths in clock states
    // ****************************************
    localparam logic [2:0] T_FETCH = 3'h4;
    localparam logic [2:0] T_MEM = 3'h3;
    localparam logic [2:0] T_SP_EXTRA = 3'h2;
    // ****************************************
    // register file indices and reset values
    // ****************************************
    localparam logic [2:0] IDX_THIRD = 3'h2;
    localparam logic [2:0] IDX_SP = 3'h3;
    localparam logic [2:0] IDX_IX = 3'h4;
    localparam logic [2:0] IDX_IY = 3'h5;
    localparam int NUM_REGS = 6;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
endpackage

/* File: rtl/sbal_core.sv */
// decode and execution of absolute 16-bit loads, stores and stack pointer copies
`timescale 1ns/1ps
module sbal_core (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [sbal_pkg::BYTE_W-1:0] mem_rdata,
    output logic [sbal_pkg::WORD_W-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [sbal_pkg::BYTE_W-1:0] mem_wdata,
    output logic opcode_fetch,
    output logic instr_done,
    output logic [sbal_pkg::WORD_W-1:0] first_pair,
    output logic [sbal_pkg::WORD_W-1:0] second_pair,
    output logic [sbal_pkg::WORD_W-1:0] third_pair,
    output logic [sbal_pkg::WORD_W-1:0] stack_pointer,
    output logic [sbal_pkg::WORD_W-1:0] index_x,
    output logic [sbal_pkg::WORD_W-1:0] index_y,
    output logic [sbal_pkg::BYTE_W-1:0] flag_reg
);
    import sbal_pkg::*;

    // ****************************************
    // state and storage
    // ****************************************
    typedef enum logic [2:0] {
        st_fetch, st_oplo, st_ophi, st_rdlo, st_rdhi, st_wrlo, st_wrhi, st_extra
    } sbal_state_t;

    sbal_state_t state;
    sbal_state_t next_state;
    logic [2:0] tcnt;
    logic [2:0] t_len;
    logic [15:0] pc;
    logic [15:0] abs_address;
    logic [7:0] prefix;
    logic [7:0] opcode;
    logic [7:0] rd_lo;
    logic [2:0] tgt;
    logic ld_mode;
    logic [15:0] reg_file [NUM_REGS];

    // ****************************************
    // decode of the byte on the bus
    // ****************************************
    wire t_last = tcnt == t_len - 3'h1;
    wire is_pre = prefix == NO_PRE && (mem_rdata == PRE_ED || mem_rdata == PRE_IX || mem_rdata == PRE_IY);
    wire pre_idx = prefix == PRE_IX || prefix == PRE_IY;
    wire ed_grp = prefix == PRE_ED && mem_rdata[7:6] == ED_GROUP;
    wire ed_ld = ed_grp && mem_rdata[3:0] == ED_LD_LOW;
    wire ed_st = ed_grp && mem_rdata[3:0] == ED_ST_LOW;
    wire idx_ld = pre_idx && mem_rdata == OP_LD_IDX;
    wire plain_st = (pre_idx || prefix == NO_PRE) && mem_rdata == OP_STORE;
    wire any_st = ed_st || plain_st;
    wire sp_cpy = prefix != PRE_ED && mem_rdata == OP_SP_COPY;
    wire go_mem = ed_ld || idx_ld || any_st;
    // pair field for ED forms, fixed register otherwise
    wire [2:0] dec_tgt = prefix == PRE_ED ? {1'b0, mem_rdata[5:4]} :
                         prefix == PRE_IX ? IDX_IX :
                         prefix == PRE_IY ? IDX_IY : IDX_THIRD;
    wire fetch_end = state == st_fetch && t_last;
    wire [15:0] addr_next = abs_address + 16'h0001;

    // ****************************************
    // machine cycle length and bus drive
    // ****************************************
    assign t_len = state == st_fetch ? T_FETCH : state == st_extra ? T_SP_EXTRA : T_MEM;
    assign opcode_fetch = state == st_fetch;
    assign mem_rd = state == st_fetch || state == st_oplo || state == st_ophi ||
                    state == st_rdlo || state == st_rdhi;
    assign mem_wr = state == st_wrlo || state == st_wrhi;
    // low byte at the operand address, high byte one above
    assign mem_addr = (state == st_rdlo || state == st_wrlo) ? abs_address :
                      (state == st_rdhi || state == st_wrhi) ? addr_next : pc;
    assign mem_wdata = state == st_wrhi ? reg_file[tgt][15:8] : reg_file[tgt][7:0];
    assign instr_done = t_last && (state == st_rdhi || state == st_wrhi || state == st_extra ||
                        (state == st_fetch && !is_pre && !go_mem && !sp_cpy));

    // next state at the last clock state of each machine cycle
    always_comb begin
        next_state = state;
        if (t_last) begin
            case (state)
                st_fetch: begin
                    if (is_pre) begin
                        next_state = st_fetch;
                    end else if (go_mem) begin
                        next_state = st_oplo;
                    end else if (sp_cpy) begin
                        next_state = st_extra;
                    end else begin
                        next_state = st_fetch;
                    end
                end
                st_oplo: next_state = st_ophi;
                st_ophi: next_state = ld_mode ? st_rdlo : st_wrlo;
                st_rdlo: next_state = st_rdhi;
                st_wrlo: next_state = st_wrhi;
                default: next_state = st_fetch;
            endcase
        end
    end

    // state and clock state counter
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= st_fetch;
            tcnt <= 3'h0;
        end else begin
            state <= next_state;
            tcnt <= t_last ? 3'h0 : tcnt + 3'h1;
        end
    end

    // program counter steps past each fetched byte
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc <= PC_RST;
        end else if (t_last && (state == st_fetch || state == st_oplo || state == st_ophi)) begin
            pc <= pc + 16'h0001;
        end
    end

    // prefix, opcode and target capture
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prefix <= NO_PRE;
            opcode <= NO_PRE;
            tgt <= IDX_THIRD;
            ld_mode <= 1'b0;
        end else if (fetch_end && is_pre) begin
            prefix <= mem_rdata;
        end else if (fetch_end) begin
            opcode <= mem_rdata;
            tgt <= dec_tgt;
            ld_mode <= ed_ld || idx_ld;
            prefix <= instr_done ? NO_PRE : prefix;
        end else if (instr_done) begin
            prefix <= NO_PRE;
        end
    end

    // operand address, earlier byte low, and first data byte
    always_ff @(posedge core_clk) begin
        if (reset) begin
            abs_address <= WORD_RST;
            rd_lo <= 8'h00;
        end else if (t_last) begin
            if (state == st_oplo) begin
                abs_address[7:0] <= mem_rdata;
            end
            if (state == st_ophi) begin
                abs_address[15:8] <= mem_rdata;
            end
            if (state == st_rdlo) begin
                rd_lo <= mem_rdata;
            end
        end
    end

    // ****************************************
    // register file
    // ****************************************
    wire wr_en = t_last && (state == st_rdhi || state == st_extra);
    wire [2:0] wr_idx = state == st_extra ? IDX_SP : tgt;
    wire [15:0] wr_val = state == st_extra ? reg_file[tgt] : {mem_rdata, rd_lo};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    reg_file[gi] <= WORD_RST;
                end else if (wr_en && wr_idx == 3'(gi)) begin
                    reg_file[gi] <= wr_val;
                end
            end
        end
    endgenerate

    assign first_pair = reg_file[0];
    assign second_pair = reg_file[1];
    assign third_pair = reg_file[2];
    assign stack_pointer = reg_file[3];
    assign index_x = reg_file[4];
    assign index_y = reg_file[5];

    // flags are held, nothing here writes them
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flag_reg <= FLAG_RST;
        end else begin
            flag_reg <= flag_reg;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // clock states since the instruction began
    logic [5:0] cyc;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cyc <= 6'h00;
        end else begin
            cyc <= instr_done ? 6'h00 : cyc + 6'h01;
        end
    end

    a_load_lo_addr: assert property (@(posedge core_clk) disable iff (reset)
        state == st_rdlo |-> mem_addr == abs_address && mem_rd) else $error("load low address wrong");
    a_addr_wrap: assert property (@(posedge core_clk) disable iff (reset)
        (state == st_rdhi || state == st_wrhi) |-> mem_addr == abs_address + 16'h0001)
        else $error("high address not plus one");
    a_store_lo_data: assert property (@(posedge core_clk) disable iff (reset)
        state == st_wrlo ##1 state == st_wrlo |-> mem_wdata == $past(reg_file[tgt][7:0]) && mem_wr)
        else $error("store low byte wrong");
    a_load_result: assert property (@(posedge core_clk) disable iff (reset)
        (state == st_rdhi && t_last) |=> reg_file[$past(tgt)] == {$past(mem_rdata), $past(rd_lo)})
        else $error("loaded word wrong");
    a_prefixed_len: assert property (@(posedge core_clk) disable iff (reset)
        (instr_done && prefix != NO_PRE && state != st_extra && state != st_fetch) |-> cyc == 6'h13)
        else $error("prefixed transfer not 20 states");
    a_plain_store_len: assert property (@(posedge core_clk) disable iff (reset)
        (instr_done && prefix == NO_PRE && state == st_wrhi) |-> cyc == 6'h0F && tgt == IDX_THIRD &&
        opcode == OP_STORE)
        else $error("plain store not 16 states");
    a_sp_copy_len: assert property (@(posedge core_clk) disable iff (reset)
        (instr_done && state == st_extra && prefix == NO_PRE) |-> cyc == 6'h05)
        else $error("plain copy not 6 states");
    a_idx_copy_len: assert property (@(posedge core_clk) disable iff (reset)
        (instr_done && state == st_extra && prefix != NO_PRE) |-> cyc == 6'h09)
        else $error("index copy not 10 states");
    a_sp_copy_val: assert property (@(posedge core_clk) disable iff (reset)
        (instr_done && state == st_extra) |=> stack_pointer == $past(reg_file[tgt]))
        else $error("copied value wrong");
    a_flags_hold: assert property (@(posedge core_clk) disable iff (reset)
        ##1 flag_reg == FLAG_RST) else $error("flags changed");
endmodule // sbal_core

/* File: sim/sbal_mem.sv */
// byte-wide memory model standing on the far side of the core
`timescale 1ns/1ps
module sbal_mem (
    input wire logic core_clk,
    input wire logic [sbal_pkg::WORD_W-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [sbal_pkg::BYTE_W-1:0] mem_wdata,
    output logic [sbal_pkg::BYTE_W-1:0] mem_rdata
);
    import sbal_pkg::*;
    // ****************************************
    // storage and bus timing
    // ****************************************
    logic [7:0] mem [0:65535];
    initial mem_rdata = 8'h00;
    // read data lags a clock, so only the late clocks of a cycle are valid
    // an idle bus shows a pattern that toggles every clock
    always @(posedge core_clk) begin
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule // sbal_mem

/* File: sim/tb_sixteen_bit_absolute_load_exec.sv */
// self-checking bench for the absolute 16-bit load, store and copy sequencer
`timescale 1ns/1ps
module tb_sixteen_bit_absolute_load_exec;
    import sbal_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [BYTE_W-1:0] mem_rdata, mem_wdata, flag_reg;
    logic [WORD_W-1:0] mem_addr;
    logic mem_rd, mem_wr, opcode_fetch, instr_done;
    logic [WORD_W-1:0] regs_seen [0:NUM_REGS-1];
    logic [WORD_W-1:0] model [0:NUM_REGS-1];
    logic [WORD_W-1:0] snap [0:63][0:NUM_REGS-1];
    logic [7:0] img [0:65535];
    logic [15:0] chk [$];
    logic [31:0] lfsr = 32'd85269;
    int exp_len [0:63];
    int exp_fetch [0:63];
    int n_instr = 0, pc = 0, n_mismatch = 0, cmp_count = 0, cycles = 0, ticks = 0, nfetch = 0;
    sbal_core u_sbal_core (.core_clk(core_clk), .reset(reset), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .opcode_fetch(opcode_fetch),
        .instr_done(instr_done), .first_pair(regs_seen[0]), .second_pair(regs_seen[1]),
        .third_pair(regs_seen[2]), .stack_pointer(regs_seen[3]), .index_x(regs_seen[4]),
        .index_y(regs_seen[5]), .flag_reg(flag_reg));
    sbal_mem u_sbal_mem (.core_clk(core_clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    // ****************************************
    // helpers
    // ****************************************
    initial forever #50 core_clk = ~core_clk;
    function automatic logic [15:0] rnd16();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            n_mismatch++;
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // memory image kept alongside the model for expectations
    task automatic poke(input logic [15:0] a, input logic [7:0] d);
        img[a] = d;
        u_sbal_mem.mem[a] = d;
    endtask
    task automatic emit(input logic [7:0] b);
        poke(16'(pc), b);
        pc++;
    endtask
    // kind 0 load, 1 store, 2 stack pointer copy, 3 no-op
    task automatic instr(input logic [7:0] pre, input logic [7:0] op, input int kind, input int r,
        input logic [15:0] a, input int len);
        if (pre != NO_PRE) emit(pre);
        emit(op);
        if (kind < 2) begin
            emit(a[7:0]);
            emit(a[15:8]);
        end
        if (kind == 0) model[r] = {img[a + 16'h1], img[a]};
        if (kind == 1) begin
            img[a] = model[r][7:0];
            img[a + 16'h1] = model[r][15:8];
            chk.push_back(a);
            chk.push_back(a + 16'h1);
        end
        if (kind == 2) model[IDX_SP] = model[r];
        snap[n_instr] = model;
        exp_len[n_instr] = len;
        exp_fetch[n_instr] = (pre != NO_PRE) ? 2 * int'(T_FETCH) : int'(T_FETCH);
        n_instr++;
    endtask
    // hang guard
    always @(posedge core_clk) begin
        ticks <= ticks + 1;
        if (ticks > 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // ****************************************
    // program build, run and compare
    // ****************************************
    initial begin
        logic [15:0] r16, a;
        int rs;
        for (int i = 0; i < NUM_REGS; i++) model[i] = WORD_RST;
        for (int r = 0; r < 2; r++) begin
            instr(NO_PRE, 8'h00, 3, 0, 16'h0000, 4);
            for (int s = 0; s < 2; s++) begin
                for (int k = 0; k < 7; k++) begin
                    r16 = rnd16();
                    a = (k == 6) ? 16'hFFFF : {r16[15:8] | 8'h80, 8'(2 * n_instr)};
                    if (s == 0 && (k != 6 || r == 0)) poke(a, r16[7:0]);
                    if (s == 0 && k != 6) poke(a + 16'h1, 8'(rnd16()));
                    rs = (k == 6) ? 2 : k;
                    instr(k == 4 ? PRE_IX : k == 5 ? PRE_IY : PRE_ED,
                        (k == 4 || k == 5) ? (s ? OP_STORE : OP_LD_IDX) : {ED_GROUP, 2'(rs), s ? ED_ST_LOW : ED_LD_LOW},
                        s, rs, a, 20);
                end
            end
            r16 = rnd16();
            instr(NO_PRE, OP_STORE, 1, IDX_THIRD, {r16[15:8] | 8'h80, 8'(2 * n_instr)}, 16);
            instr(NO_PRE, OP_SP_COPY, 2, IDX_THIRD, 16'h0000, 6);
            instr(PRE_IX, OP_SP_COPY, 2, IDX_IX, 16'h0000, 10);
            instr(PRE_IY, OP_SP_COPY, 2, IDX_IY, 16'h0000, 10);
            // corner cases: copy after the wrong prefix, and a prefix after a prefix, both no-ops
            instr(PRE_ED, OP_SP_COPY, 3, 0, 16'h0000, 8);
            instr(PRE_IX, PRE_IY, 3, 0, 16'h0000, 8);
        end
        repeat (8) emit(8'h00);
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < n_instr; i++) begin
            do begin
                @(negedge core_clk);
                cycles++;
                nfetch += int'(opcode_fetch);
            end while (instr_done !== 1'b1 && cycles < 64);
            check("instr_len", 32'(cycles), 32'(exp_len[i]));
            check("fetch_clocks", 32'(nfetch), 32'(exp_fetch[i]));
            @(negedge core_clk);
            cycles = 1;
            nfetch = int'(opcode_fetch);
            for (int k = 0; k < NUM_REGS; k++) check("register", 32'(regs_seen[k]), 32'(snap[i][k]));
            check("flag_reg", 32'(flag_reg), 32'(FLAG_RST));
        end
        foreach (chk[j]) check("mem_byte", 32'(u_sbal_mem.mem[chk[j]]), 32'(img[chk[j]]));
        tally_and_finish();
    end
endmodule // tb_sixteen_bit_absolute_load_exec
